// >>> core/fes_pkg.sv
// Purpose: shared constants for the flash status-polling host controller
// Assumes: 125 MHz mclk, 16-bit flash data bus, 22-bit word address
// Notes:   all pin timing expressed as mclk cycle counts derived here
package fes_pkg;

  // ==========================================================
  // clock and bus geometry
  localparam int CLK_PERIOD_NS = 8;
  localparam int ADDR_W        = 22;
  localparam int DATA_W        = 16;

  // ==========================================================
  // status bit positions on the data bus
  localparam int POLL_BIT      = 7;
  localparam int BUSY_TOG_BIT  = 6;
  localparam int SUSP_TOG_BIT  = 2;

  // ==========================================================
  // protect select address lines
  localparam int PROT_SEL_POS  = 6;
  localparam int PROT_ONE_POS  = 1;
  localparam int PROT_ZERO_POS = 0;

  // ==========================================================
  // bus cycle timing
  localparam int STROBE_NS     = 80;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_NS    = 30;
  localparam int RECOVER_CYC   = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_US   = 100;
  localparam int PROG_MAX_CYC  = PROG_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;

  // ==========================================================
  // command sequence values
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h00_0555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h00_02AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] PROG_CMD     = 16'h00A0;

  typedef enum {
    FES_OP_IDLE, FES_OP_WRITE, FES_OP_READ
  } fes_cyc_e;

endpackage

// >>> core/fes_bus_cycle.sv
// Purpose: one asynchronous parallel-bus read or write strobe cycle
// Assumes: caller holds address and data steady while busy is high
// Notes:   read data captured through three flops at strobe end
`timescale 1ns/1ns
module fes_bus_cycle
  import fes_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic              isWrite,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [DATA_W-1:0] flashDqIn,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdData,
  output logic                   strobeActive,
  output logic                   writeStrobe,
  output logic [DATA_W-1:0]      dqOut,
  output logic                   dqOe
);

  typedef enum {FES_BC_IDLE, FES_BC_STROBE, FES_BC_RECOVER} fes_bc_e;

  fes_bc_e            state_reg;
  logic [CNT_W-1:0]   count_reg;
  logic [DATA_W-1:0]  sync1_reg;
  logic [DATA_W-1:0]  sync2_reg;
  logic [DATA_W-1:0]  sync3_reg;

  // ==========================================================
  // input synchroniser for the data pins
  always_ff @(posedge mclk)
  begin
    sync1_reg <= flashDqIn;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
  end

  // ==========================================================
  // strobe sequencing
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg    <= FES_BC_IDLE;
      count_reg    <= '0;
      busy         <= 1'b0;
      done         <= 1'b0;
      rdData       <= '0;
      strobeActive <= 1'b0;
      writeStrobe  <= 1'b0;
      dqOut        <= '0;
      dqOe         <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        FES_BC_IDLE:
        begin
          if (start)
          begin
            state_reg    <= FES_BC_STROBE;
            count_reg    <= CNT_W'(STROBE_CYC + 3);
            busy         <= 1'b1;
            strobeActive <= 1'b1;
            writeStrobe  <= isWrite;
            dqOut        <= wrData;
            dqOe         <= isWrite;
          end
        end
        FES_BC_STROBE:
        begin
          if (count_reg == '0)
          begin
            // read strobe held until second and third stages agree
            if (isWrite || sync2_reg == sync3_reg)
            begin
              if (!isWrite)
                rdData <= sync3_reg;
              strobeActive <= 1'b0;
              writeStrobe  <= 1'b0;
              state_reg    <= FES_BC_RECOVER;
              count_reg    <= CNT_W'(RECOVER_CYC);
            end
          end
          else
            count_reg <= count_reg - 1'b1;
        end
        FES_BC_RECOVER:
        begin
          if (count_reg == '0)
          begin
            dqOe      <= 1'b0;
            busy      <= 1'b0;
            done      <= 1'b1;
            state_reg <= FES_BC_IDLE;
          end
          else
            count_reg <= count_reg - 1'b1;
        end
        default: state_reg <= FES_BC_IDLE;
      endcase
    end
  end

endmodule

// >>> core/fes_host_ctrl.sv
// Purpose: host controller that programs a word and polls flash status
// Assumes: flash on async parallel bus; one mclk domain at 125 MHz
// Notes:   supports program, protect/unprotect select and status polling
// Summary of operation
// - status reads made by cycling output enable
// - protect uses select low, one high, zero low
// - unprotect uses select line high instead
// - toggle polling may use any address
// - program starts with four bus write cycles
`timescale 1ns/1ns
module fes_host_ctrl
  import fes_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              progStart,
  input  wire logic              protStart,
  input  wire logic              unprotect,
  input  wire logic              suspendCheck,
  input  wire logic [ADDR_W-1:0] userAddr,
  input  wire logic [DATA_W-1:0] userData,
  input  wire logic [DATA_W-1:0] flashDqIn,
  output logic                   opBusy,
  output logic                   opDone,
  output logic                   opTimeout,
  output logic                   sectorSuspended,
  output logic [ADDR_W-1:0]      flashAddr,
  output logic [DATA_W-1:0]      flashDqOut,
  output logic                   flashDqOe,
  output logic                   flashCeN,
  output logic                   flashOeN,
  output logic                   flashWeN
);

  typedef enum {
    FES_IDLE, FES_CMD, FES_CMD_WAIT, FES_POLL, FES_POLL_WAIT,
    FES_SUSP, FES_SUSP_WAIT, FES_SUSP2_WAIT
  } fes_state_e;

  fes_state_e         state_reg;
  logic [1:0]         step_reg;
  logic [1:0]         lastStep_reg;
  logic [ADDR_W-1:0]  target_reg;
  logic [DATA_W-1:0]  data_reg;
  logic [DATA_W-1:0]  prevStatus_reg;
  logic               havePrev_reg;
  logic [CNT_W+2:0]   timer_reg;
  logic               timing_reg;
  logic               cycStart;
  logic               cycWrite;
  logic [DATA_W-1:0]  cycWrData;
  logic               cycBusy;
  logic               cycDone;
  logic [DATA_W-1:0]  cycRdData;
  logic               strobe;
  logic               wrStrobe;
  logic [DATA_W-1:0]  dqOutW;
  logic               dqOeW;

  // address for each step of a command sequence
  function automatic logic [ADDR_W-1:0] seqAddr(input logic [1:0] s,
                                                input logic [ADDR_W-1:0] t);
    case (s)
      2'd0:    seqAddr = UNLOCK_ADDR1;
      2'd1:    seqAddr = UNLOCK_ADDR2;
      2'd2:    seqAddr = UNLOCK_ADDR1;
      default: seqAddr = t;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] seqData(input logic [1:0] s,
                                                input logic [DATA_W-1:0] d);
    case (s)
      2'd0:    seqData = UNLOCK_DATA1;
      2'd1:    seqData = UNLOCK_DATA2;
      2'd2:    seqData = PROG_CMD;
      default: seqData = d;
    endcase
  endfunction

  fes_bus_cycle u_cycle (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .start        (cycStart),
    .isWrite      (cycWrite),
    .wrData       (cycWrData),
    .flashDqIn    (flashDqIn),
    .busy         (cycBusy),
    .done         (cycDone),
    .rdData       (cycRdData),
    .strobeActive (strobe),
    .writeStrobe  (wrStrobe),
    .dqOut        (dqOutW),
    .dqOe         (dqOeW)
  );

  // ==========================================================
  // pin drive, all registered
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      flashCeN   <= 1'b1;
      flashOeN   <= 1'b1;
      flashWeN   <= 1'b1;
      flashDqOut <= '0;
      flashDqOe  <= 1'b0;
    end
    else
    begin
      flashCeN   <= !strobe;
      flashOeN   <= !(strobe && !wrStrobe);
      flashWeN   <= !wrStrobe;
      flashDqOut <= dqOutW;
      flashDqOe  <= dqOeW;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg       <= FES_IDLE;
      step_reg        <= '0;
      lastStep_reg    <= '0;
      target_reg      <= '0;
      data_reg        <= '0;
      prevStatus_reg  <= '0;
      havePrev_reg    <= 1'b0;
      flashAddr       <= '0;
      cycStart        <= 1'b0;
      cycWrite        <= 1'b0;
      cycWrData       <= '0;
      opBusy          <= 1'b0;
      opDone          <= 1'b0;
      opTimeout       <= 1'b0;
      sectorSuspended <= 1'b0;
    end
    else
    begin
      cycStart <= 1'b0;
      opDone   <= 1'b0;
      case (state_reg)
        FES_IDLE:
        begin
          if (progStart)
          begin
            target_reg   <= userAddr;
            data_reg     <= userData;
            step_reg     <= 2'd0;
            lastStep_reg <= 2'd3;
            opBusy       <= 1'b1;
            opTimeout    <= 1'b0;
            state_reg    <= FES_CMD;
          end
          else if (protStart)
          begin
            target_reg <= userAddr;
            target_reg[PROT_SEL_POS]  <= unprotect;
            target_reg[PROT_ONE_POS]  <= 1'b1;
            target_reg[PROT_ZERO_POS] <= 1'b0;
            data_reg     <= userData;
            step_reg     <= 2'd3;
            lastStep_reg <= 2'd3;
            opBusy       <= 1'b1;
            opTimeout    <= 1'b0;
            state_reg    <= FES_CMD;
          end
          else if (suspendCheck)
          begin
            target_reg <= userAddr;
            opBusy     <= 1'b1;
            state_reg  <= FES_SUSP;
          end
        end
        FES_CMD:
        begin
          flashAddr <= seqAddr(step_reg, target_reg);
          cycWrData <= seqData(step_reg, data_reg);
          cycWrite  <= 1'b1;
          cycStart  <= 1'b1;
          state_reg <= FES_CMD_WAIT;
        end
        FES_CMD_WAIT:
        begin
          if (cycDone)
          begin
            if (step_reg == lastStep_reg)
            begin
              havePrev_reg <= 1'b0;
              state_reg    <= FES_POLL;
            end
            else
            begin
              step_reg  <= step_reg + 2'd1;
              state_reg <= FES_CMD;
            end
          end
        end
        FES_POLL:
        begin
          flashAddr <= target_reg;
          cycWrite  <= 1'b0;
          cycStart  <= 1'b1;
          state_reg <= FES_POLL_WAIT;
        end
        FES_POLL_WAIT:
        begin
          if (cycDone)
          begin
            prevStatus_reg <= cycRdData;
            havePrev_reg   <= 1'b1;
            // stop on matching poll bit or stable toggle
            if ((cycRdData[POLL_BIT] == data_reg[POLL_BIT]) ||
                (havePrev_reg &&
                 cycRdData[BUSY_TOG_BIT] == prevStatus_reg[BUSY_TOG_BIT]))
            begin
              opBusy    <= 1'b0;
              opDone    <= 1'b1;
              state_reg <= FES_IDLE;
            end
            else if (timing_reg && timer_reg >= (CNT_W+3)'(PROG_MAX_CYC))
            begin
              opBusy    <= 1'b0;
              opDone    <= 1'b1;
              opTimeout <= 1'b1;
              state_reg <= FES_IDLE;
            end
            else
              state_reg <= FES_POLL;
          end
        end
        FES_SUSP:
        begin
          flashAddr <= target_reg;
          cycWrite  <= 1'b0;
          cycStart  <= 1'b1;
          state_reg <= FES_SUSP_WAIT;
        end
        FES_SUSP_WAIT:
        begin
          if (cycDone)
          begin
            prevStatus_reg <= cycRdData;
            cycStart       <= 1'b1;
            state_reg      <= FES_SUSP2_WAIT;
          end
        end
        FES_SUSP2_WAIT:
        begin
          if (cycDone)
          begin
            // toggling here marks an erase-suspended sector
            sectorSuspended <= cycRdData[SUSP_TOG_BIT] != prevStatus_reg[SUSP_TOG_BIT];
            opBusy          <= 1'b0;
            opDone          <= 1'b1;
            state_reg       <= FES_IDLE;
          end
        end
        default: state_reg <= FES_IDLE;
      endcase
    end
  end

  // ==========================================================
  // program duration watchdog
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      timer_reg  <= '0;
      timing_reg <= 1'b0;
    end
    else if (state_reg == FES_CMD_WAIT && cycDone && step_reg == lastStep_reg)
    begin
      timer_reg  <= '0;
      timing_reg <= 1'b1;
    end
    else if (state_reg == FES_IDLE)
      timing_reg <= 1'b0;
    else if (timing_reg && !(&timer_reg))
      timer_reg <= timer_reg + 1'b1;
  end

endmodule

// >>> test/fes_host_ctrl_props.sv
// Purpose: concurrent checks on the host controller pins
// Assumes: one mclk domain, sync active-low reset
// Notes:   helper logic tracks the running operation kind
`timescale 1ns/1ns
module fes_host_ctrl_props
  import fes_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              progStart,
  input wire logic              protStart,
  input wire logic              unprotect,
  input wire logic              suspendCheck,
  input wire logic [ADDR_W-1:0] userAddr,
  input wire logic              opBusy,
  input wire logic              opDone,
  input wire logic              opTimeout,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_W-1:0] flashDqOut,
  input wire logic              flashDqOe,
  input wire logic              flashCeN,
  input wire logic              flashOeN,
  input wire logic              flashWeN
);
  // ==========================================================
  // operation tracking
  logic [1:0]        kind_reg;
  logic [2:0]        wrCnt_reg;
  logic              polled_reg;
  logic [14:0]       cyc_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              goNow;
  assign goNow = !opBusy && (progStart || protStart || suspendCheck);
  always_ff @(posedge mclk)
  begin
    if (!rst_n || goNow)
    begin
      kind_reg <= progStart ? 2'h1 : (protStart ? {1'b1, unprotect} : 2'h0);
      wrCnt_reg <= 3'h0;
      polled_reg <= 1'b0;
      cyc_reg <= 15'h0000;
      addr_reg <= userAddr;
    end
    else
    begin
      if ($fell(flashWeN))
        wrCnt_reg <= wrCnt_reg + 3'h1;
      if ($fell(flashOeN) && wrCnt_reg == 3'h4)
        polled_reg <= 1'b1;
      if (!(&cyc_reg))
        cyc_reg <= cyc_reg + 15'h0001;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_prot; $fell(flashWeN) && kind_reg == 2'h2 |-> !flashAddr[PROT_SEL_POS]
    && flashAddr[PROT_ONE_POS] && !flashAddr[PROT_ZERO_POS]; endproperty
  a_prot: assert property (p_prot) else $error("protect address lines wrong");
  property p_unprot; $fell(flashWeN) && kind_reg == 2'h3 |-> flashAddr[PROT_SEL_POS]
    && flashAddr[PROT_ONE_POS] && !flashAddr[PROT_ZERO_POS]; endproperty
  a_unprot: assert property (p_unprot) else $error("unprotect address lines wrong");
  property p_unlock; $fell(flashWeN) && kind_reg == 2'h1 && wrCnt_reg == 3'h0 |->
    flashAddr == UNLOCK_ADDR1 && flashDqOut == UNLOCK_DATA1 && flashDqOe; endproperty
  a_unlock: assert property (p_unlock) else $error("first unlock write wrong");
  property p_cmd; $fell(flashWeN) && kind_reg == 2'h1 && wrCnt_reg == 3'h2 |->
    flashAddr == UNLOCK_ADDR1 && flashDqOut == PROG_CMD; endproperty
  a_cmd: assert property (p_cmd) else $error("program command write wrong");
  property p_polled; opDone && kind_reg == 2'h1 |-> polled_reg && wrCnt_reg == 3'h4;
  endproperty
  a_polled: assert property (p_polled) else $error("program done without polling");
  property p_tmo; $rose(opTimeout) |-> kind_reg == 2'h1 && cyc_reg >= PROG_MAX_CYC;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout raised early");
  property p_saddr; $fell(flashOeN) && opBusy && kind_reg == 2'h0 |-> flashAddr == addr_reg;
  endproperty
  a_saddr: assert property (p_saddr) else $error("suspend read at wrong address");
  property p_excl; flashWeN || flashOeN; endproperty
  a_excl: assert property (p_excl) else $error("write and read strobes overlap");
  property p_rst; $rose(rst_n) |-> flashCeN && flashOeN && flashWeN && !flashDqOe && !opBusy;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  c_prog: cover property (opDone && kind_reg == 2'h1);
  c_unprot: cover property (opDone && kind_reg == 2'h3);
  c_tmo: cover property ($rose(opTimeout));
endmodule
bind fes_host_ctrl fes_host_ctrl_props chk_u (.mclk(mclk), .rst_n(rst_n),
  .progStart(progStart), .protStart(protStart), .unprotect(unprotect),
  .suspendCheck(suspendCheck), .userAddr(userAddr), .opBusy(opBusy), .opDone(opDone),
  .opTimeout(opTimeout), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
  .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN));

// >>> test/fes_flash_model.sv
// Purpose: behavioural flash with program and status polling
// Assumes: strobes sampled on mclk; one erase-suspended sector
// Notes:   released data lines show the inverse of the last read
`timescale 1ns/1ns
module fes_flash_model
  import fes_pkg::*;
#(
  parameter logic [6:0] SUSP_SEC = 7'h25
)
(
  input  wire logic              mclk,
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire logic [DATA_W-1:0] flashDqOut,
  input  wire logic              flashCeN,
  input  wire logic              flashOeN,
  input  wire logic              flashWeN,
  input  wire logic [15:0]       busyCyc,
  output logic      [DATA_W-1:0] flashDqIn,
  output logic      [DATA_W-1:0] progWord = 16'h0000,
  output logic      [ADDR_W-1:0] protAddr = 22'h00_0000,
  output logic                   busyNow
);
  logic [1:0]        stage = 2'h0;
  logic [15:0]       left = 16'h0000;
  logic              weQ = 1'b1;
  logic              oeQ = 1'b1;
  logic              ceQ = 1'b1;
  logic              tog = 1'b0;
  logic              susp = 1'b0;
  logic              inSusp;
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] lastQ = 16'h0000;
  assign busyNow = left != 16'h0000;
  assign inSusp = flashAddr[21:15] == SUSP_SEC;
  always_comb
  begin
    rd = inSusp ? 16'h0000 : progWord;
    if (busyNow)
      rd[POLL_BIT] = ~progWord[POLL_BIT];
    if (busyNow)
      rd[BUSY_TOG_BIT] = tog;
    if (inSusp)
      rd[SUSP_TOG_BIT] = susp;
  end
  assign flashDqIn = (!flashOeN && !flashCeN) ? rd : ~lastQ;
  always_ff @(posedge mclk)
  begin
    weQ <= flashWeN;
    oeQ <= flashOeN;
    ceQ <= flashCeN;
    if (busyNow)
      left <= left - 16'h0001;
    if (!flashWeN && !flashCeN)
    begin
      wa <= flashAddr;
      wd <= flashDqOut;
    end
    if (!flashOeN && !flashCeN)
      lastQ <= rd;
    if (!flashOeN && !flashCeN && (oeQ || ceQ))
    begin
      tog <= busyNow ? ~tog : tog;
      susp <= inSusp ? ~susp : susp;
    end
    if (!weQ && flashWeN)
    begin
      stage <= 2'h0;
      case (stage)
        2'h0: if (wa == UNLOCK_ADDR1 && wd == UNLOCK_DATA1) stage <= 2'h1;
              else if (wa[PROT_ONE_POS] && !wa[PROT_ZERO_POS]) protAddr <= wa;
        2'h1: if (wa == UNLOCK_ADDR2 && wd == UNLOCK_DATA2) stage <= 2'h2;
        2'h2: if (wa == UNLOCK_ADDR1 && wd == PROG_CMD) stage <= 2'h3;
        default:
        begin
          progWord <= wd;
          left <= busyCyc;
        end
      endcase
    end
  end
endmodule

// >>> test/fes_host_ctrl_tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: 125 MHz mclk, model answers on the same clock
// Notes:   one task per scenario, shared start and compare tasks
`timescale 1ns/1ns
module fes_host_ctrl_tb
  import fes_pkg::*;
;
  logic              mclk;
  logic              rst_n;
  logic              progStart;
  logic              protStart;
  logic              unprotect;
  logic              suspendCheck;
  logic [ADDR_W-1:0] userAddr;
  logic [DATA_W-1:0] userData;
  logic [DATA_W-1:0] flashDqIn;
  logic              opBusy;
  logic              opDone;
  logic              opTimeout;
  logic              sectorSuspended;
  logic [ADDR_W-1:0] flashAddr;
  logic [DATA_W-1:0] flashDqOut;
  logic              flashDqOe;
  logic              flashCeN;
  logic              flashOeN;
  logic              flashWeN;
  logic [15:0]       busyCyc;
  logic [DATA_W-1:0] progWord;
  logic [ADDR_W-1:0] protAddr;
  logic              busyNow;
  int                n_mismatch = 0;
  int                n_checks = 0;
  fes_host_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .progStart(progStart),
    .protStart(protStart), .unprotect(unprotect), .suspendCheck(suspendCheck),
    .userAddr(userAddr), .userData(userData), .flashDqIn(flashDqIn), .opBusy(opBusy),
    .opDone(opDone), .opTimeout(opTimeout), .sectorSuspended(sectorSuspended),
    .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN));
  fes_flash_model flash_u (.mclk(mclk), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .busyCyc(busyCyc),
    .flashDqIn(flashDqIn), .progWord(progWord), .protAddr(protAddr), .busyNow(busyNow));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic go(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic u, input logic [15:0] b);
    int n;
    @(posedge mclk);
    userAddr <= a;
    userData <= d;
    unprotect <= u;
    busyCyc <= b;
    progStart <= k == 0;
    protStart <= k == 1;
    suspendCheck <= k == 2;
    @(posedge mclk);
    progStart <= 1'b0;
    protStart <= 1'b0;
    suspendCheck <= 1'b0;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (opDone !== 1'b1 && n < 20000);
    chk(n < 20000, 1'b1);
    repeat (2) @(negedge mclk);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_prog(input logic [DATA_W-1:0] d, input logic [15:0] b, input logic to);
    go(0, 22'h01_0040, d, 1'b0, b);
    chk(progWord, d);
    chk(opTimeout, to);
    chk(busyNow, to);
    chk(opBusy, 1'b0);
  endtask
  task automatic t_prot(input logic [ADDR_W-1:0] a, input logic u);
    go(1, a, 16'h00C3, u, 16'h0000);
    chk(protAddr, {a[21:7], u, a[5:2], 2'b10});
  endtask
  task automatic t_susp(input logic [ADDR_W-1:0] a, input logic e);
    go(2, a, 16'h0000, 1'b0, 16'h0000);
    chk(sectorSuspended, e);
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    repeat (80000) @(posedge mclk);
    n_mismatch++;
    close_out;
  end
  initial
  begin
    rst_n = 1'b0;
    progStart = 1'b0;
    protStart = 1'b0;
    unprotect = 1'b0;
    suspendCheck = 1'b0;
    userAddr = 22'h00_0000;
    userData = 16'h0000;
    busyCyc = 16'h0000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk({flashCeN, flashOeN, flashWeN, flashDqOe, opBusy}, 5'b11100);
    t_prog(16'h8A5C, 16'd750, 1'b0);
    t_prog(16'h31E7, 16'd3, 1'b0);
    t_prot(22'h12_3445, 1'b0);
    t_prot(22'h12_3405, 1'b1);
    t_susp(22'h12_8123, 1'b1);
    t_susp(22'h00_4123, 1'b0);
    t_prog(16'h0F80, 16'd13000, 1'b1);
    close_out;
  end
endmodule
